// ==== design/alu_pkg.sv ====
// Package for the element-wise vector integer and fixed-point datapath.
// Assumes one core clock, and an issue stage and register file on the same clock feeding one element per request.
// Functional notes
// RL1: Accumulate form: dest = a*b + old dest.
// RL2: Negated accumulate: dest = old dest - a*b.
// RL3: Multiplicand form: dest = a*old dest + b.
// RL4: Negated multiplicand: dest = b - a*old dest.
// RL5: Only low product half joins the sum.
// RL6: Widening: full double product plus double dest.
// RL7: Widening signs: uu, ss, signed-a unsigned-b.
// RL8: Merge writes every body element, mask ignored.
// RL9: Merge: mask zero takes b, else a.
// RL10: Merge a: vector, scalar or signed imm5.
// RL11: Move needs b register zero, else reserved.
// RL12: Move copies vector or splats scalar/immediate.
// RL13: Vector move onto itself is a no-op.
// RL14: Saturating add/sub clip and set flag.
// RL15: Saturating subtracts have no immediate form.
// RL16: Averaging: shift right one, round per mode.
// RL17: Averaging subtract overflow wraps silently.
// RL18: Fractional multiply: shift, round, saturate, flag.
// RL19: Saturation flag sticky, set only by elements.
// RL20: Masked-off elements follow the mask policy.
package alu_pkg;

  localparam int EW = 32;
  localparam int DW = 2 * EW;
  localparam int IDX_W = 8;
  localparam int ADDR_W = 12;
  localparam int RW = 5;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 12'h008;

  localparam int CTRL_RM_LSB = 0;
  localparam int CTRL_POLICY_BIT = 2;
  localparam int STATUS_SAT_BIT = 0;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic STATUS_RESET = 1'b0;
  localparam logic [EW-1:0] COUNT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {RM_RNU, RM_RNE, RM_RDN, RM_ROD} rm_e;

  typedef enum logic [1:0] {SRC_VV, SRC_VX, SRC_VI} src_e;

  typedef enum logic [4:0] {
    OP_MACC, OP_NMSAC, OP_MADD, OP_NMSUB,
    OP_WMACCU, OP_WMACC, OP_WMACCSU,
    OP_MERGE,
    OP_SADDU, OP_SADD, OP_SSUBU, OP_SSUB,
    OP_AADDU, OP_AADD, OP_ASUBU, OP_ASUB,
    OP_SMUL
  } op_e;

  typedef struct packed {
    op_e op;
    src_e src;
    logic mask_enable_field;
    logic mask_bit;
    logic [RW-1:0] vreg_a_num;
    logic [RW-1:0] vreg_b_num;
    logic [RW-1:0] vreg_d_num;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] start_idx;
    logic [IDX_W-1:0] active_vector_length;
    logic [EW-1:0] vec_a;
    logic [EW-1:0] vec_b;
    logic [EW-1:0] scalar;
    logic [4:0] imm5;
    logic [DW-1:0] dest_old;
  } req_s;

  typedef struct packed {
    logic valid;
    logic wr_en;
    logic reserved;
    logic sat;
    logic [IDX_W-1:0] idx;
    logic [DW-1:0] data;
  } resp_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [EW-1:0] pwdata;
  } apb_s;

endpackage

// ==== design/vec_fxp_alu.sv ====
// Element-wise vector integer and fixed-point execution datapath with an APB control slave.
// Assumes the issue stage presents one element per request on the core clock and accepts one result a cycle later.
`timescale 1ns/100ps
module vec_fxp_alu (
  input wire logic i_mclk, // Core clock, 40 MHz.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic i_valid, // Element request present.
  input wire alu_pkg::req_s i_req, // Element operands and instruction fields.
  output logic o_ready, // Request can be taken.
  output alu_pkg::resp_s o_resp, // Registered element result.
  input wire alu_pkg::apb_s i_apb, // APB request.
  output logic [alu_pkg::EW-1:0] o_prdata, // APB read data.
  output logic o_pready, // APB ready.
  output logic o_pslverr, // APB error on unmapped address.
  output logic o_sat_flag // Sticky saturation flag.
);
  import alu_pkg::*;

  // Rounding increment for a right shift: lsb kept, first bit dropped, any lower bit dropped.
  function automatic logic round_inc(input rm_e rm, input logic keep_lsb, input logic drop_msb,
                                     input logic drop_rest);
    unique case (rm)
      RM_RNU: round_inc = drop_msb;
      RM_RNE: round_inc = drop_msb & (drop_rest | keep_lsb);
      RM_RDN: round_inc = 1'b0;
      RM_ROD: round_inc = ~keep_lsb & (drop_msb | drop_rest);
    endcase
  endfunction

  logic [2:0] ctrl_reg;
  logic sat_reg;
  logic sat_next;
  logic [EW-1:0] count_reg;
  logic [EW-1:0] prdata_reg;
  resp_s resp_reg;
  resp_s resp_next;
  req_s r;
  rm_e rm;
  logic agnostic;

  assign r = i_req;
  assign rm = rm_e'(ctrl_reg[CTRL_RM_LSB +: 2]);
  assign agnostic = ctrl_reg[CTRL_POLICY_BIT];
  assign o_ready = ~i_rst;

  wire take = i_valid & o_ready;

  // Operand a: vector element, scalar, or sign-extended immediate.
  wire [EW-1:0] op1 = (r.src == SRC_VV) ? r.vec_a :
                      (r.src == SRC_VX) ? r.scalar : {{(EW-5){r.imm5[4]}}, r.imm5}; // see RL10
  wire [EW-1:0] old_lo = r.dest_old[EW-1:0];

  // Element classification.
  wire body = (r.idx >= r.start_idx) && (r.idx < r.active_vector_length);
  wire active = body & (r.mask_enable_field | r.mask_bit);
  wire is_merge = (r.op == OP_MERGE);
  wire is_move = is_merge & r.mask_enable_field;
  wire vi_ok = is_merge | (r.op == OP_SADDU) | (r.op == OP_SADD);
  wire bad_move = is_move & (r.vreg_b_num != '0); // see RL11
  wire bad_imm = (r.src == SRC_VI) & ~vi_ok; // see RL15
  wire reserved = bad_move | bad_imm;
  wire self_move = is_move & (r.src == SRC_VV) & (r.vreg_a_num == r.vreg_d_num); // see RL13
  wire computed = is_merge ? body : active; // see RL8
  wire masked_off = body & ~computed;

  // Single-width multiply-add: low product half only.
  wire over_mcand = (r.op == OP_MADD) | (r.op == OP_NMSUB);
  wire negate = (r.op == OP_NMSAC) | (r.op == OP_NMSUB);
  wire [EW-1:0] mul_rhs = over_mcand ? old_lo : r.vec_b;
  wire [EW-1:0] addend = over_mcand ? r.vec_b : old_lo;
  wire [DW-1:0] mul_full = {{EW{1'b0}}, op1} * {{EW{1'b0}}, mul_rhs};
  wire [EW-1:0] mul_lo = mul_full[EW-1:0]; // see RL5
  wire [EW-1:0] macc_res = negate ? addend - mul_lo : addend + mul_lo; // see RL1 RL2 RL3 RL4

  // Widening multiply-add over operands sign- or zero-extended per op.
  wire wa_sign = (r.op != OP_WMACCU) & op1[EW-1]; // see RL7
  wire wb_sign = (r.op == OP_WMACC) & r.vec_b[EW-1];
  wire [DW-1:0] w_prod_full = {{EW{wa_sign}}, op1} * {{EW{wb_sign}}, r.vec_b};
  wire [DW-1:0] wmacc_res = w_prod_full + r.dest_old; // see RL6

  // Merge and move: mask set or unmasked takes operand a.
  wire [EW-1:0] mv_res = (r.mask_enable_field | r.mask_bit) ? op1 : r.vec_b; // see RL9 RL12

  // Saturating add and subtract, b op a.
  wire [EW:0] uadd = {1'b0, r.vec_b} + {1'b0, op1};
  wire [EW:0] usub = {1'b0, r.vec_b} - {1'b0, op1};
  wire [EW-1:0] sadd = r.vec_b + op1;
  wire [EW-1:0] ssub = r.vec_b - op1;
  wire sadd_ov = (r.vec_b[EW-1] == op1[EW-1]) & (sadd[EW-1] != r.vec_b[EW-1]);
  wire ssub_ov = (r.vec_b[EW-1] != op1[EW-1]) & (ssub[EW-1] != r.vec_b[EW-1]);
  wire [EW-1:0] s_clip = r.vec_b[EW-1] ? {1'b1, {(EW-1){1'b0}}} : {1'b0, {(EW-1){1'b1}}};

  // Averaging add and subtract in one extra bit, then shift by one with rounding.
  wire avg_signed = (r.op == OP_AADD) | (r.op == OP_ASUB);
  wire avg_sub = (r.op == OP_ASUBU) | (r.op == OP_ASUB);
  wire [EW:0] avg_b = {avg_signed & r.vec_b[EW-1], r.vec_b};
  wire [EW:0] avg_a = {avg_signed & op1[EW-1], op1};
  wire [EW:0] avg_wide = avg_sub ? avg_b - avg_a : avg_b + avg_a;
  wire avg_inc = round_inc(rm, avg_wide[1], avg_wide[0], 1'b0);
  wire [EW-1:0] avg_res = avg_wide[EW:1] + {{(EW-1){1'b0}}, avg_inc}; // see RL16 RL17

  // Signed fractional multiply: shift by width-1, round, clip.
  wire [DW-1:0] f_prod = {{EW{r.vec_b[EW-1]}}, r.vec_b} * {{EW{op1[EW-1]}}, op1};
  wire f_inc = round_inc(rm, f_prod[EW-1], f_prod[EW-2], |f_prod[EW-3:0]);
  wire [EW:0] f_shift = f_prod[DW-1:EW-1];
  wire [EW:0] f_round = f_shift + {{EW{1'b0}}, f_inc};
  wire f_ov = (f_round[EW] != f_round[EW-1]); // see RL18
  wire [EW-1:0] f_res = f_ov ? (f_round[EW] ? {1'b1, {(EW-1){1'b0}}} : {1'b0, {(EW-1){1'b1}}})
                             : f_round[EW-1:0];

  logic [DW-1:0] res_data;
  logic res_sat;

  always_comb begin
    res_data = '0;
    res_sat = 1'b0;
    unique case (r.op)
      OP_MACC, OP_NMSAC, OP_MADD, OP_NMSUB: res_data = {{EW{1'b0}}, macc_res};
      OP_WMACCU, OP_WMACC, OP_WMACCSU: res_data = wmacc_res;
      OP_MERGE: res_data = {{EW{1'b0}}, mv_res};
      OP_SADDU: begin
        res_sat = uadd[EW]; // see RL14
        res_data = {{EW{1'b0}}, uadd[EW] ? {EW{1'b1}} : uadd[EW-1:0]};
      end
      OP_SADD: begin
        res_sat = sadd_ov;
        res_data = {{EW{1'b0}}, sadd_ov ? s_clip : sadd};
      end
      OP_SSUBU: begin
        res_sat = usub[EW];
        res_data = {{EW{1'b0}}, usub[EW] ? {EW{1'b0}} : usub[EW-1:0]};
      end
      OP_SSUB: begin
        res_sat = ssub_ov;
        res_data = {{EW{1'b0}}, ssub_ov ? s_clip : ssub};
      end
      OP_AADDU, OP_AADD, OP_ASUBU, OP_ASUB: res_data = {{EW{1'b0}}, avg_res};
      OP_SMUL: begin
        res_sat = f_ov;
        res_data = {{EW{1'b0}}, f_res};
      end
      default: res_data = '0;
    endcase
  end

  // Masked-off elements: undisturbed leaves the destination, agnostic writes all ones.
  wire do_write = take & ~reserved & ~self_move & (computed | (masked_off & agnostic)); // see RL20
  wire sat_event = take & ~reserved & computed & res_sat;

  always_comb begin
    resp_next = '0;
    resp_next.valid = take;
    resp_next.wr_en = do_write;
    resp_next.reserved = take & reserved;
    resp_next.sat = sat_event;
    resp_next.idx = r.idx;
    resp_next.data = computed ? res_data : {DW{1'b1}};
  end

  // APB slave: zero wait states, registered read data captured in the setup phase.
  wire apb_setup = i_apb.psel & ~i_apb.penable;
  wire apb_access = i_apb.psel & i_apb.penable;
  wire hit_ctrl = (i_apb.paddr == CTRL_OFS);
  wire hit_status = (i_apb.paddr == STATUS_OFS);
  wire hit_count = (i_apb.paddr == COUNT_OFS);
  wire mapped = hit_ctrl | hit_status | hit_count;
  wire wr_ok = apb_access & i_apb.pwrite & mapped;
  wire sat_clear = wr_ok & hit_status & i_apb.pwdata[STATUS_SAT_BIT];
  wire [EW-1:0] rd_mux = hit_ctrl ? {{(EW-3){1'b0}}, ctrl_reg} :
                         hit_status ? {{(EW-1){1'b0}}, sat_reg} :
                         hit_count ? count_reg : '0;

  assign sat_next = sat_event | (sat_reg & ~sat_clear); // see RL19

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RESET;
      sat_reg <= STATUS_RESET;
      count_reg <= COUNT_RESET;
      prdata_reg <= '0;
      resp_reg <= '0;
    end else begin
      if (wr_ok & hit_ctrl) begin
        ctrl_reg <= i_apb.pwdata[2:0];
      end
      sat_reg <= sat_next;
      if (do_write) begin
        count_reg <= count_reg + 32'h0000_0001;
      end
      if (apb_setup) begin
        prdata_reg <= rd_mux;
      end
      resp_reg <= resp_next;
    end
  end

  assign o_resp = resp_reg;
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = apb_access & ~mapped;
  assign o_sat_flag = sat_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_MACC: assert property ($past(take & computed & ~reserved) && $past(r.op) == OP_MACC // see RL1
    |-> o_resp.data[EW-1:0] == $past(old_lo) + EW'($past(op1) * $past(r.vec_b)))
    else $error("accumulate result wrong");
  AST_NMSAC: assert property ($past(take & computed & ~reserved) && $past(r.op) == OP_NMSAC // see RL2
    |-> o_resp.data[EW-1:0] == $past(old_lo) - EW'($past(op1) * $past(r.vec_b)))
    else $error("negated accumulate result wrong");
  AST_MADD: assert property ($past(take & computed & ~reserved) && $past(r.op) == OP_MADD // see RL3
    |-> o_resp.data[EW-1:0] == $past(r.vec_b) + EW'($past(op1) * $past(old_lo)))
    else $error("multiplicand form result wrong");
  AST_NMSUB: assert property ($past(take & computed & ~reserved) && $past(r.op) == OP_NMSUB // see RL4
    |-> o_resp.data[EW-1:0] == $past(r.vec_b) - EW'($past(op1) * $past(old_lo)))
    else $error("negated multiplicand result wrong");
  AST_LOW_HALF: assert property (take && computed && r.op inside {OP_MACC, OP_MADD} // see RL5
    |=> o_resp.data[DW-1:EW] == '0)
    else $error("single-width result has upper bits");
  AST_WIDE_SS: assert property (take && computed && !reserved && r.op == OP_WMACC // see RL6
    |=> $signed(o_resp.data) == $signed($past(r.dest_old)) + $signed($past(op1)) * $signed($past(r.vec_b)))
    else $error("signed widening result wrong");
  AST_WIDE_UU: assert property (take && computed && !reserved && r.op == OP_WMACCU // see RL7
    |=> o_resp.data == $past(r.dest_old) + DW'({32'h0, $past(op1)} * {32'h0, $past(r.vec_b)}))
    else $error("unsigned widening result wrong");
  AST_MERGE_BODY: assert property (take && is_merge && !is_move && body // see RL8
    |=> o_resp.wr_en)
    else $error("merge skipped a body element");
  AST_MERGE_SEL: assert property (take && is_merge && !r.mask_enable_field && !r.mask_bit && body // see RL9
    |=> o_resp.data[EW-1:0] == $past(r.vec_b))
    else $error("merge took wrong operand");
  AST_MOVE_RSVD: assert property (take && is_move && r.vreg_b_num != '0 // see RL11
    |=> o_resp.reserved && !o_resp.wr_en)
    else $error("reserved move not flagged");
  AST_SUB_IMM: assert property (take && r.src == SRC_VI && r.op inside {OP_SSUBU, OP_SSUB} // see RL15
    |=> o_resp.reserved)
    else $error("immediate subtract not reserved");
  AST_SAT_SET: assert property (o_resp.sat |-> o_sat_flag) // see RL14
    else $error("saturation flag not set");
  AST_SAT_STICKY: assert property ($fell(o_sat_flag) |-> $past(sat_clear)) // see RL19
    else $error("saturation flag cleared without software");
  AST_SMUL_CLIP: assert property (take && computed && r.op == OP_SMUL && r.vec_b == 32'h8000_0000 // see RL18
    && op1 == 32'h8000_0000 |=> o_resp.sat && o_resp.data[EW-1:0] == 32'h7fff_ffff)
    else $error("fractional multiply did not clip");
  AST_MASK_OFF: assert property (take && masked_off && !agnostic && !reserved // see RL20
    |=> !o_resp.wr_en && !o_resp.sat)
    else $error("masked-off element written under undisturbed policy");

  COV_MERGE: cover property (take && is_merge && !is_move && body && r.mask_bit);
  COV_SAT: cover property (sat_event ##1 o_sat_flag [*2]);
  COV_SMUL: cover property (take && r.op == OP_SMUL && f_ov);
  COV_AGNOSTIC: cover property (take && masked_off && agnostic);

endmodule // vec_fxp_alu

// ==== tb/issue_model.sv ====
// Model of the issue stage and register file that feed the datapath one element per request.
// Assumes the bench stages a request and pulses i_send on the core clock.
`timescale 1ns/100ps
module issue_model (
  input wire logic i_mclk, // Core clock.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic i_send, // Present the staged request next cycle.
  input wire alu_pkg::req_s i_stage, // Request staged by the bench.
  output logic o_valid, // Request present.
  output alu_pkg::req_s o_req // Request fields.
);
  import alu_pkg::*;
  // Between requests the fields toggle every cycle so that stale operands cannot pass for fresh ones.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_req <= '0;
    end else begin
      o_valid <= i_send;
      o_req <= i_send ? i_stage : ~o_req;
    end
  end
endmodule // issue_model

// ==== tb/testbench.sv ====
// Self-checking bench for the vector fixed-point datapath and its control registers.
// Assumes issue_model feeds the element port and the bench is the APB master.
`timescale 1ns/100ps
module testbench;
  import alu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic snd = 1'b0;
  req_s stg = '0;
  req_s req;
  logic vld, o_ready, o_pready, o_pslverr, o_sat_flag, err, sat_x = 1'b0, pol = 1'b0;
  resp_s o_resp;
  apb_s bus = '0;
  logic [EW-1:0] o_prdata, rd;
  logic [31:0] seed = 32'd96481;
  logic [1:0] rm = 2'h0;
  logic [ADDR_W-1:0] ofs [3] = '{CTRL_OFS, STATUS_OFS, COUNT_OFS};
  int miscompares = 0, compares = 0, wr_x = 0;
  always #12.5 i_mclk = ~i_mclk;
  issue_model u_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_send(snd), .i_stage(stg), .o_valid(vld), .o_req(req));
  vec_fxp_alu u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(vld), .i_req(req), .o_ready(o_ready),
    .o_resp(o_resp), .i_apb(bus), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_sat_flag(o_sat_flag));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Biased towards the signed extremes, where saturation and wrap live.
  function automatic logic [31:0] pk();
    logic [31:0] v;
    v = xs();
    return (v[1:0] == 2'h0) ? {v[2], {31{~v[2]}}} : xs();
  endfunction
  function automatic longint ro(longint v, int sh);
    logic l, h, s, r;
    l = v[sh];
    h = v[sh-1];
    s = (sh > 1) && ((v & ((64'h1 << (sh - 1)) - 1)) != 0);
    case (rm)
      2'h0: r = h;
      2'h1: r = h & (s | l);
      2'h2: r = 1'b0;
      default: r = ~l & (h | s);
    endcase
    return (v >>> sh) + longint'(r);
  endfunction
  function automatic logic [32:0] sc(longint v);
    if (v > longint'(32'h7fffffff)) return 33'h17fffffff;
    if (v < -longint'(32'h80000000)) return 33'h180000000;
    return {1'b0, v[31:0]};
  endfunction
  function automatic logic [32:0] uc(longint v);
    if (v > longint'(32'hffffffff)) return 33'h1ffffffff;
    if (v < 0) return 33'h100000000;
    return {1'b0, v[31:0]};
  endfunction
  function automatic resp_s ex(req_s r);
    resp_s e;
    logic [31:0] av;
    logic [32:0] c;
    longint a, ua, b, ub, d, w, v;
    logic mv;
    av = (r.src == SRC_VV) ? r.vec_a : (r.src == SRC_VX) ? r.scalar : {{27{r.imm5[4]}}, r.imm5};
    ua = longint'(av);
    a = longint'(signed'(av));
    ub = longint'(r.vec_b);
    b = longint'(signed'(r.vec_b));
    d = longint'(r.dest_old[31:0]);
    w = longint'(r.dest_old);
    mv = (r.op == OP_MERGE) && r.mask_enable_field;
    e = '0;
    e.valid = 1'b1;
    e.idx = r.idx;
    e.reserved = (mv && r.vreg_b_num != 0) || (r.src == SRC_VI && !(r.op inside {OP_MERGE, OP_SADDU, OP_SADD}));
    if (e.reserved || r.idx < r.start_idx || r.idx >= r.active_vector_length) return e;
    if (mv && r.src == SRC_VV && r.vreg_a_num == r.vreg_d_num) return e;
    if (!(r.mask_enable_field || r.mask_bit || r.op == OP_MERGE)) begin
      e.wr_en = pol;
      e.data = '1;
      return e;
    end
    e.wr_en = 1'b1;
    c = '0;
    v = 0;
    case (r.op)
      OP_MACC: v = a * b + d;
      OP_NMSAC: v = d - a * b;
      OP_MADD: v = a * d + b;
      OP_NMSUB: v = b - a * d;
      OP_WMACCU: v = ua * ub + w;
      OP_WMACC: v = a * b + w;
      OP_WMACCSU: v = a * ub + w;
      OP_MERGE: v = (mv || r.mask_bit) ? ua : ub;
      OP_SADDU: c = uc(ub + ua);
      OP_SADD: c = sc(b + a);
      OP_SSUBU: c = uc(ub - ua);
      OP_SSUB: c = sc(b - a);
      OP_AADDU: v = ro(ub + ua, 1);
      OP_AADD: v = ro(b + a, 1);
      OP_ASUBU: v = ro(ub - ua, 1);
      OP_ASUB: v = ro(b - a, 1);
      default: c = sc(ro(b * a, EW - 1));
    endcase
    e.sat = c[32];
    if (r.op inside {OP_SADDU, OP_SADD, OP_SSUBU, OP_SSUB, OP_SMUL}) v = longint'(c[31:0]);
    e.data = (r.op inside {OP_WMACCU, OP_WMACC, OP_WMACCSU}) ? v : {32'h0, v[31:0]};
    return e;
  endfunction
  function automatic req_s mk(op_e op, src_e s, logic [31:0] a, logic [31:0] b);
    req_s r;
    r = '0;
    r.op = op;
    r.src = s;
    r.mask_enable_field = 1'b1;
    r.mask_bit = 1'b1;
    r.vreg_a_num = 5'h1;
    r.vreg_d_num = 5'h2;
    r.idx = 8'h1;
    r.active_vector_length = 8'h8;
    r.vec_a = a;
    r.scalar = a;
    r.imm5 = a[4:0];
    r.vec_b = b;
    r.dest_old = {xs(), xs()};
    return r;
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic ck(logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic ab(logic wr, logic [ADDR_W-1:0] addr, logic [31:0] wd);
    int k;
    @(posedge i_mclk);
    bus.psel <= 1'b1;
    bus.pwrite <= wr;
    bus.paddr <= addr;
    bus.pwdata <= wd;
    @(posedge i_mclk);
    bus.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    err = o_pslverr;
    bus.psel <= 1'b0;
    bus.penable <= 1'b0;
    if (k == 20) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic el(req_s r);
    resp_s e;
    e = ex(r);
    @(posedge i_mclk);
    snd <= 1'b1;
    stg <= r;
    @(posedge i_mclk);
    snd <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    ck(64'({o_resp.valid, o_resp.wr_en, o_resp.reserved, o_resp.sat, o_resp.idx}),
      64'({e.valid, e.wr_en, e.reserved, e.sat, e.idx}));
    if (e.wr_en) ck(o_resp.data, e.data);
    sat_x = sat_x | e.sat;
    wr_x += int'(e.wr_en);
    ck(64'(o_sat_flag), 64'(sat_x));
  endtask
  initial begin
    req_s r;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    ab(1'b1, 12'h00c, 32'h7);
    ck(64'({o_ready, err}), 64'h3);
    foreach (ofs[i]) begin
      ab(1'b0, ofs[i], 32'h0);
      ck(64'({err, rd}), 64'h0);
    end
    el(mk(OP_SADD, SRC_VV, 32'h1, 32'h7fffffff));
    el(mk(OP_SADDU, SRC_VI, 32'h1f, 32'h2));
    el(mk(OP_SSUB, SRC_VI, 32'h1, 32'h2));
    el(mk(OP_SSUBU, SRC_VX, 32'h5, 32'h3));
    el(mk(OP_SMUL, SRC_VV, 32'h80000000, 32'h80000000));
    el(mk(OP_ASUB, SRC_VV, 32'h80000000, 32'h7fffffff));
    ab(1'b0, STATUS_OFS, 32'h0);
    ck(64'(rd), 64'(sat_x));
    ab(1'b1, STATUS_OFS, 32'h1);
    sat_x = 1'b0;
    @(negedge i_mclk);
    ck(64'(o_sat_flag), 64'h0);
    r = mk(OP_MERGE, SRC_VI, 32'h10, 32'h55);
    r.mask_enable_field = 1'b0;
    el(r);
    r.mask_bit = 1'b0;
    el(r);
    r.mask_enable_field = 1'b1;
    r.src = SRC_VX;
    el(r);
    r.vreg_b_num = 5'h3;
    el(r);
    r.vreg_b_num = 5'h0;
    r.src = SRC_VV;
    r.vreg_a_num = 5'h2;
    el(r);
    r = mk(OP_MACC, SRC_VV, 32'h3, 32'h4);
    r.idx = 8'h8;
    el(r);
    r.idx = 8'h0;
    r.start_idx = 8'h1;
    el(r);
    for (int m = 0; m < 8; m++) begin
      {pol, rm} = 3'(m);
      ab(1'b1, CTRL_OFS, 32'(m));
      ab(1'b0, CTRL_OFS, 32'h0);
      ck(64'(rd), 64'(m));
      repeat (40) begin
        r = mk(op_e'(5'(xs() % 17)), src_e'(2'(xs() % 3)), pk(), pk());
        {r.mask_enable_field, r.mask_bit} = 2'(xs());
        r.vreg_a_num = 5'(xs() % 3);
        r.vreg_b_num = 5'(xs() % 2);
        r.idx = 8'(xs() % 10);
        r.start_idx = 8'(xs() % 2);
        r.scalar = pk();
        r.dest_old = {pk(), pk()};
        el(r);
      end
    end
    ab(1'b0, COUNT_OFS, 32'h0);
    ck(64'(rd), 64'(wr_x));
    ab(1'b0, STATUS_OFS, 32'h0);
    ck(64'(rd), 64'(sat_x));
    give_verdict();
  end
endmodule // testbench
